// ### hw/hbp_device.sv
`timescale 1ns/1ps
// Contract
// - host sets write data before 4th edge
// - host keeps byte strobes high one clock
// - host holds strobes until ack low
// - drive ack inactive once select and strobe
// - ack high after strobe, release next edge
// - read data valid soon after ack low
// - host holds address stable until strobe rises
// - read data driven only after byte strobe
// - sized mode acks on port size line
// - sized mode decodes address, size, direction
// - host holds data strobe until ack low
// - host raises data strobe with address strobe
// - sized mode samples write on 4th edge
// - fixed mode cycle is ten clocks, no ack
// - fixed mode captures write on 4th edge
// - fixed mode read valid by divider count
// - fixed mode blocks block transfer engine
// - fixed mode drives read only when enabled
module hbp_device
   import hbp_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // protocol strap
   input wire logic [2:0] cfg_mode,
   // host bus
   hbp_bus_if.device bus,
   // internal target
   output logic tgt_req,
   output logic tgt_write,
   output logic tgt_mem,
   output logic [16:0] tgt_addr,
   output logic [1:0] tgt_be,
   output logic [15:0] tgt_wdata,
   input wire logic tgt_done,
   input wire logic [15:0] tgt_rdata
);
   // ****************************************
   // state
   // ****************************************
   typedef enum logic [4:0] {
      HBP_D_IDLE = 5'b00001,
      HBP_D_COUNT = 5'b00010,
      HBP_D_ACCESS = 5'b00100,
      HBP_D_ACK = 5'b01000,
      HBP_D_RELEASE = 5'b10000
   } hbp_dev_state_t;

   hbp_dev_state_t state_reg;
   hbp_mode_t mode_reg;
   logic strap_done_reg;
   logic [3:0] edge_cnt_reg;
   logic ack_n_reg;
   logic ack_oe_reg;
   logic is_read_reg;
   logic [15:0] rdata_reg;

   logic sel;
   logic strobe_any;
   logic start_cond;
   logic qual;
   logic [3:0] cnt_now;
   logic fire;
   logic [1:0] be_now;
   logic blt_hit;
   logic bus_end;

   // ****************************************
   // strap capture
   // ****************************************
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         strap_done_reg <= 1'b0;
         mode_reg <= HBP_MODE_STROBE;
      end else if (!strap_done_reg) begin
         strap_done_reg <= 1'b1;
         case (cfg_mode)
            HBP_MODE_SIZED: mode_reg <= HBP_MODE_SIZED;
            HBP_MODE_FIXED: mode_reg <= HBP_MODE_FIXED;
            default: mode_reg <= HBP_MODE_STROBE;
         endcase
      end
   end

   // ****************************************
   // cycle decode
   // ****************************************
   always_comb begin
      sel = strap_done_reg && !bus.cs_n;
      be_now = 2'h0;
      strobe_any = 1'b0;
      start_cond = 1'b0;
      case (mode_reg)
         HBP_MODE_SIZED: begin
            strobe_any = !bus.data_strobe_n;
            start_cond = sel && !bus.address_strobe_n;
            if (bus.transfer_size == HBP_SIZE_BYTE) begin
               be_now = bus.addr[0] ? 2'h1 : 2'h2;
            end else begin
               be_now = 2'h3;
            end
         end
         HBP_MODE_FIXED: begin
            be_now = {!bus.byte_enable_high_n, !bus.byte_enable_low_n};
            strobe_any = |be_now;
            start_cond = sel && strobe_any;
         end
         default: begin
            be_now = {!bus.upper_byte_strobe_n, !bus.lower_byte_strobe_n};
            strobe_any = |be_now;
            start_cond = sel && !bus.address_strobe_n;
         end
      endcase
      qual = start_cond && strobe_any;
      blt_hit = (bus.addr >= HBP_BLT_ADDR_LO) && (bus.addr <= HBP_BLT_ADDR_HI);
      bus_end = (mode_reg == HBP_MODE_FIXED) ? !start_cond : bus.address_strobe_n;
      cnt_now = (state_reg == HBP_D_IDLE) ? 4'h0 : edge_cnt_reg;
      // reads start on the first edge, writes sample on the 4th
      if (bus.read_not_write) begin
         fire = qual && (cnt_now == 4'h0);
      end else begin
         fire = qual && (cnt_now == HBP_SAMPLE_EDGE - 4'h1);
      end
   end

   // ****************************************
   // cycle sequencer
   // ****************************************
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state_reg <= HBP_D_IDLE;
         edge_cnt_reg <= 4'h0;
      end else begin
         case (state_reg)
            HBP_D_IDLE: begin
               if (start_cond) begin
                  edge_cnt_reg <= cnt_now + {3'h0, qual};
                  if (fire && mode_reg == HBP_MODE_FIXED && blt_hit) begin
                     state_reg <= HBP_D_ACK;
                  end else if (fire) begin
                     state_reg <= HBP_D_ACCESS;
                  end else begin
                     state_reg <= HBP_D_COUNT;
                  end
               end
            end
            HBP_D_COUNT: begin
               edge_cnt_reg <= cnt_now + {3'h0, qual};
               if (bus_end) begin
                  state_reg <= HBP_D_RELEASE;
               end else if (fire && mode_reg == HBP_MODE_FIXED && blt_hit) begin
                  state_reg <= HBP_D_ACK;
               end else if (fire) begin
                  state_reg <= HBP_D_ACCESS;
               end
            end
            HBP_D_ACCESS: begin
               if (tgt_done) begin
                  state_reg <= HBP_D_ACK;
               end
            end
            HBP_D_ACK: begin
               if (bus_end) begin
                  state_reg <= HBP_D_RELEASE;
               end
            end
            default: begin
               state_reg <= HBP_D_IDLE;
            end
         endcase
      end
   end

   // ****************************************
   // target request
   // ****************************************
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         tgt_req <= 1'b0;
         tgt_write <= 1'b0;
         tgt_mem <= 1'b0;
         tgt_addr <= 17'h00000;
         tgt_be <= 2'h0;
         tgt_wdata <= 16'h0000;
         is_read_reg <= 1'b0;
      end else begin
         tgt_req <= 1'b0;
         if ((state_reg == HBP_D_IDLE || state_reg == HBP_D_COUNT) && fire) begin
            tgt_req <= !(mode_reg == HBP_MODE_FIXED && blt_hit);
            tgt_write <= !bus.read_not_write;
            tgt_mem <= bus.mem_sel;
            tgt_addr <= bus.addr;
            tgt_be <= be_now;
            tgt_wdata <= bus.data;
            is_read_reg <= bus.read_not_write;
         end
      end
   end

   // ****************************************
   // read data hold
   // ****************************************
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rdata_reg <= 16'h0000;
      end else if (state_reg == HBP_D_ACCESS && tgt_done) begin
         rdata_reg <= tgt_rdata;
      end else if (state_reg != HBP_D_ACK && fire && mode_reg == HBP_MODE_FIXED && blt_hit) begin
         rdata_reg <= 16'h0000;
      end
   end

   // ****************************************
   // acknowledge line
   // ****************************************
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ack_n_reg <= 1'b1;
         ack_oe_reg <= 1'b0;
      end else if (mode_reg == HBP_MODE_FIXED) begin
         ack_n_reg <= 1'b1;
         ack_oe_reg <= 1'b0;
      end else begin
         case (state_reg)
            HBP_D_IDLE: begin
               ack_n_reg <= 1'b1;
               ack_oe_reg <= start_cond;
            end
            HBP_D_ACCESS: begin
               ack_n_reg <= !tgt_done;
            end
            HBP_D_ACK: begin
               ack_n_reg <= bus_end;
            end
            HBP_D_RELEASE: begin
               ack_n_reg <= 1'b1;
               ack_oe_reg <= 1'b0;
            end
            default: begin
               ack_n_reg <= 1'b1;
            end
         endcase
      end
   end

   // ****************************************
   // bus outputs
   // ****************************************
   assign bus.ack_out_n = ack_n_reg;
   assign bus.transfer_ack_oe = ack_oe_reg && (mode_reg == HBP_MODE_STROBE);
   assign bus.port_size_ack_oe = ack_oe_reg && (mode_reg == HBP_MODE_SIZED);
   assign bus.dev_data = rdata_reg;
   // lanes driven only while their strobe is low in a read
   always_comb begin
      bus.dev_data_oe = 2'h0;
      if (state_reg == HBP_D_ACK && is_read_reg && sel && bus.read_not_write) begin
         if (mode_reg == HBP_MODE_FIXED) begin
            bus.dev_data_oe = bus.out_en_n ? 2'h0 : be_now;
         end else if (mode_reg == HBP_MODE_SIZED) begin
            bus.dev_data_oe = strobe_any ? be_now : 2'h0;
         end else begin
            bus.dev_data_oe = be_now;
         end
      end
   end
endmodule

// ### hw/hbp_pkg.sv
package hbp_pkg;
   // ****************************************
   // widths and protocol selection
   // ****************************************
   localparam int HBP_ADDR_W = 17;
   localparam int HBP_DATA_W = 16;
   typedef enum logic [2:0] {
      HBP_MODE_STROBE = 3'b001,
      HBP_MODE_SIZED = 3'b010,
      HBP_MODE_FIXED = 3'b100
   } hbp_mode_t;
   // ****************************************
   // transfer size codes
   // ****************************************
   localparam logic [1:0] HBP_SIZE_BYTE = 2'h1;
   localparam logic [1:0] HBP_SIZE_WORD = 2'h2;
   // ****************************************
   // bus clock period in ns, timing counts in bus clocks
   // ****************************************
   localparam int HBP_CLK_PERIOD_NS = 25;
   localparam logic [3:0] HBP_SAMPLE_EDGE = 4'h4;
   localparam logic [3:0] HBP_FIXED_CYCLE_CLKS = 4'ha;
   localparam logic [3:0] HBP_STROBE_GAP_CLKS = 4'h1;
   localparam logic [3:0] HBP_RD_VALID_DIV1 = 4'h5;
   localparam logic [3:0] HBP_RD_VALID_DIV2 = 4'h8;
   localparam logic [3:0] HBP_RD_VALID_DIV3 = 4'ha;
   localparam logic [3:0] HBP_RD_VALID_DIV4 = 4'hd;
   // ****************************************
   // block transfer engine window
   // ****************************************
   localparam logic [16:0] HBP_BLT_ADDR_LO = 17'h10000;
   localparam logic [16:0] HBP_BLT_ADDR_HI = 17'h1ffff;
   // divider code 0..3 means divide by 1..4
   function automatic logic [3:0] hbp_read_valid_clks(input logic [1:0] div);
      case (div)
         2'h0: hbp_read_valid_clks = HBP_RD_VALID_DIV1;
         2'h1: hbp_read_valid_clks = HBP_RD_VALID_DIV2;
         2'h2: hbp_read_valid_clks = HBP_RD_VALID_DIV3;
         default: hbp_read_valid_clks = HBP_RD_VALID_DIV4;
      endcase
   endfunction
endpackage

// ### hw/hbp_bus_if.sv
`timescale 1ns/1ps
interface hbp_bus_if;
   // ****************************************
   // host driven
   // ****************************************
   logic cs_n;
   logic address_strobe_n;
   logic upper_byte_strobe_n;
   logic lower_byte_strobe_n;
   logic data_strobe_n;
   logic [1:0] transfer_size;
   logic byte_enable_low_n;
   logic byte_enable_high_n;
   logic out_en_n;
   logic read_not_write;
   logic mem_sel;
   logic [16:0] addr;
   logic [15:0] host_data;
   logic [1:0] host_data_oe;
   // ****************************************
   // device driven
   // ****************************************
   logic [15:0] dev_data;
   logic [1:0] dev_data_oe;
   logic ack_out_n;
   logic transfer_ack_oe;
   logic port_size_ack_oe;
   // ****************************************
   // resolved wires, acks pulled up
   // ****************************************
   logic [15:0] data;
   logic transfer_ack_n;
   logic port_size_ack_n;
   assign data[15:8] = dev_data_oe[1] ? dev_data[15:8] : (host_data_oe[1] ? host_data[15:8] : 8'h00);
   assign data[7:0] = dev_data_oe[0] ? dev_data[7:0] : (host_data_oe[0] ? host_data[7:0] : 8'h00);
   assign transfer_ack_n = transfer_ack_oe ? ack_out_n : 1'b1;
   assign port_size_ack_n = port_size_ack_oe ? ack_out_n : 1'b1;
   modport host (
      output cs_n, address_strobe_n, upper_byte_strobe_n, lower_byte_strobe_n,
      output data_strobe_n, transfer_size, byte_enable_low_n, byte_enable_high_n,
      output out_en_n, read_not_write, mem_sel, addr, host_data, host_data_oe,
      input data, transfer_ack_n, port_size_ack_n
   );
   modport device (
      input cs_n, address_strobe_n, upper_byte_strobe_n, lower_byte_strobe_n,
      input data_strobe_n, transfer_size, byte_enable_low_n, byte_enable_high_n,
      input out_en_n, read_not_write, mem_sel, addr, data,
      output dev_data, dev_data_oe, ack_out_n, transfer_ack_oe, port_size_ack_oe
   );
endinterface

// ### hw/hbp_host.sv
`timescale 1ns/1ps
module hbp_host
   import hbp_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // configuration
   input wire logic [2:0] mode,
   input wire logic [1:0] mclk_div,
   // command port
   input wire logic cmd_valid,
   output logic cmd_ready,
   input wire logic cmd_write,
   input wire logic cmd_mem,
   input wire logic [16:0] cmd_addr,
   input wire logic [1:0] cmd_be,
   input wire logic [15:0] cmd_wdata,
   output logic rsp_valid,
   output logic [15:0] rsp_rdata,
   // host bus
   hbp_bus_if.host bus
);
   // ****************************************
   // state
   // ****************************************
   typedef enum logic [5:0] {
      HBP_H_IDLE = 6'b000001,
      HBP_H_ADDR = 6'b000010,
      HBP_H_WAIT = 6'b000100,
      HBP_H_CAPT = 6'b001000,
      HBP_H_END = 6'b010000,
      HBP_H_GAP = 6'b100000
   } hbp_host_state_t;

   hbp_host_state_t state_reg;
   logic [3:0] timer_reg;
   logic write_reg;
   logic [1:0] be_reg;
   logic fixed;
   logic ack_seen;

   assign fixed = (mode == HBP_MODE_FIXED);
   assign ack_seen = (mode == HBP_MODE_SIZED) ? !bus.port_size_ack_n : !bus.transfer_ack_n;
   assign cmd_ready = (state_reg == HBP_H_IDLE);

   // ****************************************
   // sequencer and pins
   // ****************************************
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state_reg <= HBP_H_IDLE;
         timer_reg <= 4'h0;
         write_reg <= 1'b0;
         be_reg <= 2'h0;
         rsp_valid <= 1'b0;
         rsp_rdata <= 16'h0000;
         bus.cs_n <= 1'b1;
         bus.address_strobe_n <= 1'b1;
         bus.upper_byte_strobe_n <= 1'b1;
         bus.lower_byte_strobe_n <= 1'b1;
         bus.data_strobe_n <= 1'b1;
         bus.transfer_size <= HBP_SIZE_WORD;
         bus.byte_enable_low_n <= 1'b1;
         bus.byte_enable_high_n <= 1'b1;
         bus.out_en_n <= 1'b1;
         bus.read_not_write <= 1'b1;
         bus.mem_sel <= 1'b0;
         bus.addr <= 17'h00000;
         bus.host_data <= 16'h0000;
         bus.host_data_oe <= 2'h0;
      end else begin
         rsp_valid <= 1'b0;
         case (state_reg)
            HBP_H_IDLE: begin
               if (cmd_valid) begin
                  write_reg <= cmd_write;
                  be_reg <= cmd_be;
                  bus.addr <= cmd_addr;
                  bus.mem_sel <= cmd_mem;
                  bus.read_not_write <= !cmd_write;
                  bus.cs_n <= 1'b0;
                  bus.transfer_size <= (&cmd_be) ? HBP_SIZE_WORD : HBP_SIZE_BYTE;
                  timer_reg <= 4'h0;
                  if (fixed) begin
                     bus.byte_enable_high_n <= !cmd_be[1];
                     bus.byte_enable_low_n <= !cmd_be[0];
                     bus.out_en_n <= cmd_write;
                     bus.host_data <= cmd_wdata;
                     bus.host_data_oe <= cmd_write ? cmd_be : 2'h0;
                     state_reg <= HBP_H_WAIT;
                  end else begin
                     bus.address_strobe_n <= 1'b0;
                     bus.host_data <= cmd_wdata;
                     state_reg <= HBP_H_ADDR;
                  end
               end
            end
            HBP_H_ADDR: begin
               // data goes out with the strobes, well ahead of the 4th edge
               bus.host_data_oe <= write_reg ? 2'h3 : 2'h0;
               if (mode == HBP_MODE_SIZED) begin
                  bus.data_strobe_n <= 1'b0;
               end else begin
                  bus.upper_byte_strobe_n <= !be_reg[1];
                  bus.lower_byte_strobe_n <= !be_reg[0];
               end
               state_reg <= HBP_H_WAIT;
            end
            HBP_H_WAIT: begin
               timer_reg <= timer_reg + 4'h1;
               if (fixed) begin
                  if (!write_reg && (timer_reg == hbp_read_valid_clks(mclk_div)
                     || timer_reg == HBP_FIXED_CYCLE_CLKS - 4'h2)) begin
                     rsp_rdata <= bus.data;
                  end
                  if (timer_reg == HBP_FIXED_CYCLE_CLKS - 4'h2) begin
                     state_reg <= HBP_H_END;
                  end
               end else if (ack_seen) begin
                  // strobes stay low until the ack is seen
                  state_reg <= write_reg ? HBP_H_END : HBP_H_CAPT;
               end
            end
            HBP_H_CAPT: begin
               rsp_rdata <= bus.data;
               state_reg <= HBP_H_END;
            end
            HBP_H_END: begin
               // data strobe and address strobe rise together
               bus.cs_n <= 1'b1;
               bus.address_strobe_n <= 1'b1;
               bus.data_strobe_n <= 1'b1;
               bus.upper_byte_strobe_n <= 1'b1;
               bus.lower_byte_strobe_n <= 1'b1;
               bus.byte_enable_low_n <= 1'b1;
               bus.byte_enable_high_n <= 1'b1;
               bus.out_en_n <= 1'b1;
               bus.host_data_oe <= 2'h0;
               rsp_valid <= 1'b1;
               timer_reg <= 4'h0;
               state_reg <= HBP_H_GAP;
            end
            default: begin
               timer_reg <= timer_reg + 4'h1;
               if (timer_reg + 4'h1 >= HBP_STROBE_GAP_CLKS) begin
                  state_reg <= HBP_H_IDLE;
               end
            end
         endcase
      end
   end
endmodule

// ### verif/hbp_bus_props.sv
`timescale 1ns/1ps
// ****************************************
// bus rule checker
// ****************************************
module hbp_bus_props
   import hbp_pkg::*;
(
   // clock, reset and strap
   input wire logic clk,
   input wire logic rstn,
   input wire logic [2:0] cfg_mode,
   // host driven
   input wire logic cs_n,
   input wire logic address_strobe_n,
   input wire logic upper_byte_strobe_n,
   input wire logic lower_byte_strobe_n,
   input wire logic data_strobe_n,
   input wire logic [1:0] transfer_size,
   input wire logic byte_enable_low_n,
   input wire logic byte_enable_high_n,
   input wire logic out_en_n,
   input wire logic read_not_write,
   input wire logic [16:0] addr,
   // device driven
   input wire logic [15:0] dev_data,
   input wire logic [1:0] dev_data_oe,
   input wire logic transfer_ack_n,
   input wire logic transfer_ack_oe,
   input wire logic port_size_ack_oe
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstn);
   // ****************************************
   // select low time counter
   // ****************************************
   logic [4:0] low_cnt_reg;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         low_cnt_reg <= 5'h00;
      end else if (cs_n) begin
         low_cnt_reg <= 5'h00;
      end else if (low_cnt_reg != 5'h1f) begin
         low_cnt_reg <= low_cnt_reg + 5'h01;
      end
   end
   // ****************************************
   // assertions
   // ****************************************
   chk_ack_drive_start: assert property (
      cfg_mode == HBP_MODE_STROBE && $fell(address_strobe_n) && !cs_n
      |=> transfer_ack_oe && transfer_ack_n) else $error("ack not driven high at start");
   chk_ack_release: assert property (
      cfg_mode == HBP_MODE_STROBE && $rose(address_strobe_n) && transfer_ack_oe
      |=> transfer_ack_oe && transfer_ack_n ##1 !transfer_ack_oe)
      else $error("ack not raised then released");
   chk_rd_data_hold: assert property (
      cfg_mode == HBP_MODE_STROBE && $fell(transfer_ack_n) && read_not_write
      |-> dev_data_oe == ~{upper_byte_strobe_n, lower_byte_strobe_n} ##1 $stable(dev_data))
      else $error("read data not on bus with ack");
   chk_lane_strobe: assert property (
      cfg_mode == HBP_MODE_STROBE && dev_data_oe != 2'h0
      |-> read_not_write && (dev_data_oe & {upper_byte_strobe_n, lower_byte_strobe_n}) == 2'h0)
      else $error("data lane driven without its strobe");
   chk_lane_sized: assert property (
      cfg_mode == HBP_MODE_SIZED && dev_data_oe != 2'h0 |-> !data_strobe_n && read_not_write
      && dev_data_oe == (transfer_size == HBP_SIZE_WORD ? 2'h3 : (addr[0] ? 2'h1 : 2'h2)))
      else $error("sized read lanes wrong");
   chk_lane_fixed: assert property (
      cfg_mode == HBP_MODE_FIXED && dev_data_oe != 2'h0
      |-> !out_en_n && (dev_data_oe & {byte_enable_high_n, byte_enable_low_n}) == 2'h0)
      else $error("fixed read driven without enables");
   chk_psz_ack_start: assert property (
      cfg_mode == HBP_MODE_SIZED && $fell(address_strobe_n) && !cs_n |=> port_size_ack_oe)
      else $error("port size ack not driven");
   chk_ack_mode_only: assert property (
      !(transfer_ack_oe && cfg_mode != HBP_MODE_STROBE)
      && !(port_size_ack_oe && cfg_mode != HBP_MODE_SIZED))
      else $error("ack line of another protocol driven");
   chk_fixed_cycle_len: assert property (
      cfg_mode == HBP_MODE_FIXED && $rose(cs_n) |-> low_cnt_reg == {1'b0, HBP_FIXED_CYCLE_CLKS})
      else $error("fixed cycle length wrong");
   cov_strobe_read: cover property (
      cfg_mode == HBP_MODE_STROBE && $fell(transfer_ack_n) && read_not_write);
   cov_sized_end: cover property (port_size_ack_oe && $rose(address_strobe_n));
   cov_fixed_end: cover property (cfg_mode == HBP_MODE_FIXED && $rose(cs_n));
endmodule

// ### verif/hbp_tb_top.sv
`timescale 1ns/1ps
module host_bus_slave_port_tb_top;
   import hbp_pkg::*;
   // ****************************************
   // signals and model state
   // ****************************************
   logic clk, rstn, cmd_valid, cmd_ready, cmd_write, cmd_mem, rsp_valid;
   logic tgt_req, tgt_write, tgt_mem, tgt_done, cur_w, cur_m, req_seen;
   logic [2:0] mode;
   logic [1:0] mclk_div, cmd_be, tgt_be, cur_be;
   logic [16:0] cmd_addr, tgt_addr, cur_a;
   logic [15:0] cmd_wdata, rsp_rdata, tgt_wdata, tgt_rdata, cur_wd, tmask;
   int bad_count, comparisons, lat, k;
   int unsigned seed = 27;
   int ref_mem [int];
   logic [15:0] tmem [int];
   hbp_bus_if bus ();
   hbp_host hbp_host_inst (.clk(clk), .rstn(rstn), .mode(mode), .mclk_div(mclk_div),
      .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_write(cmd_write), .cmd_mem(cmd_mem),
      .cmd_addr(cmd_addr), .cmd_be(cmd_be), .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid),
      .rsp_rdata(rsp_rdata), .bus(bus));
   hbp_device hbp_device_inst (.clk(clk), .rstn(rstn), .cfg_mode(mode), .bus(bus),
      .tgt_req(tgt_req), .tgt_write(tgt_write), .tgt_mem(tgt_mem), .tgt_addr(tgt_addr),
      .tgt_be(tgt_be), .tgt_wdata(tgt_wdata), .tgt_done(tgt_done), .tgt_rdata(tgt_rdata));
   hbp_bus_props hbp_bus_props_inst (.clk(clk), .rstn(rstn), .cfg_mode(mode),
      .cs_n(bus.cs_n), .address_strobe_n(bus.address_strobe_n),
      .upper_byte_strobe_n(bus.upper_byte_strobe_n),
      .lower_byte_strobe_n(bus.lower_byte_strobe_n), .data_strobe_n(bus.data_strobe_n),
      .transfer_size(bus.transfer_size), .byte_enable_low_n(bus.byte_enable_low_n),
      .byte_enable_high_n(bus.byte_enable_high_n), .out_en_n(bus.out_en_n),
      .read_not_write(bus.read_not_write), .addr(bus.addr), .dev_data(bus.dev_data),
      .dev_data_oe(bus.dev_data_oe), .transfer_ack_n(bus.transfer_ack_n),
      .transfer_ack_oe(bus.transfer_ack_oe), .port_size_ack_oe(bus.port_size_ack_oe));
   // ****************************************
   // helpers
   // ****************************************
   function automatic int unsigned rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic [15:0] ref_rd(input int key);
      return ref_mem.exists(key) ? ref_mem[key][15:0] : 16'h0000;
   endfunction
   task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
      comparisons++;
      if (seen !== exp) begin
         bad_count++;
         $display("BAD %0t %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask
   task automatic end_sim();
      if (bad_count == 0 && comparisons > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic restart(input int m, input int d);
      @(posedge clk);
      rstn <= 1'b0;
      mode <= 3'(1 << m);
      mclk_div <= 2'(d);
      repeat (4) @(posedge clk);
      rstn <= 1'b1;
   endtask
   // one host command, compared with the model
   task automatic do_cmd(input logic w, input logic [16:0] a, input logic [1:0] be,
      input logic [15:0] wd);
      logic [15:0] mask;
      logic blk;
      int n;
      int key;
      mask = {{8{be[1]}}, {8{be[0]}}};
      cur_m = 1'(rnd());
      cur_w = w;
      cur_a = a;
      cur_be = be;
      cur_wd = wd;
      req_seen = 1'b0;
      key = int'({cur_m, a[16:1]});
      blk = mode == HBP_MODE_FIXED && a >= HBP_BLT_ADDR_LO;
      @(posedge clk);
      cmd_valid <= 1'b1;
      cmd_write <= w;
      cmd_mem <= cur_m;
      cmd_addr <= a;
      cmd_be <= be;
      cmd_wdata <= wd;
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (cmd_ready !== 1'b1 && n < 50);
      @(posedge clk);
      cmd_valid <= 1'b0;
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (rsp_valid !== 1'b1 && n < 300);
      check(16'(rsp_valid), 16'h0001, "response");
      if (!w) begin
         check(rsp_rdata & mask, blk ? 16'h0000 : ref_rd(key) & mask, "read data");
      end else if (!blk) begin
         ref_mem[key] = int'((ref_rd(key) & ~mask) | (wd & mask));
      end
      check(16'(req_seen), 16'(!blk), "target request");
   endtask
   task automatic rnd_op();
      logic [1:0] be;
      logic [16:0] a;
      be = 2'(rnd() % 3 + 1);
      a = 17'(rnd() & 32'h1f);
      a[0] = (be == 2'h1);
      do_cmd(1'(rnd()), a, be, 16'(rnd()));
   endtask
   // ****************************************
   // clock, target and watchdog
   // ****************************************
   initial begin
      clk = 1'b0;
      forever begin
         #(HBP_CLK_PERIOD_NS / 2.0) clk = ~clk;
      end
   end
   always begin
      @(negedge clk);
      if (tgt_req === 1'b1) begin
         req_seen = 1'b1;
         tmask = {{8{tgt_be[1]}}, {8{tgt_be[0]}}};
         check(16'(tgt_write), 16'(cur_w), "target dir");
         check(16'(tgt_mem), 16'(cur_m), "target space");
         check(16'(tgt_addr[16:1]), 16'(cur_a[16:1]), "target addr");
         check(16'(tgt_be), 16'(cur_be), "target lanes");
         k = int'({tgt_mem, tgt_addr[16:1]});
         if (tgt_write) begin
            check(tgt_wdata & tmask, cur_wd & tmask, "write data");
            tmem[k] = ((tmem.exists(k) ? tmem[k] : 16'h0000) & ~tmask) | (tgt_wdata & tmask);
         end
         lat = (mode == HBP_MODE_FIXED) ? 0 : int'(rnd() % 5);
         repeat (lat) @(posedge clk);
         @(posedge clk);
         tgt_done <= 1'b1;
         tgt_rdata <= tmem.exists(k) ? tmem[k] : 16'h0000;
         @(posedge clk);
         tgt_done <= 1'b0;
      end
   end
   initial begin
      repeat (30000) @(posedge clk);
      bad_count++;
      end_sim();
   end
   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      rstn = 1'b0;
      mode = 3'h1;
      mclk_div = 2'h0;
      cmd_valid = 1'b0;
      cmd_write = 1'b0;
      cmd_mem = 1'b0;
      cmd_addr = 17'h00000;
      cmd_be = 2'h3;
      cmd_wdata = 16'h0000;
      tgt_done = 1'b0;
      tgt_rdata = 16'h0000;
      for (int m = 0; m < 3; m++) begin
         for (int d = 0; d < 4; d++) begin
            restart(m, d);
            repeat (14) rnd_op();
            if (m == 2) begin
               do_cmd(1'b1, 17'h0ffff, 2'h1, 16'h5aa5);
               do_cmd(1'b1, HBP_BLT_ADDR_LO, 2'h3, 16'h1234);
               do_cmd(1'b0, HBP_BLT_ADDR_LO, 2'h3, 16'h0000);
               do_cmd(1'b0, HBP_BLT_ADDR_HI, 2'h1, 16'h0000);
               do_cmd(1'b0, 17'h0ffff, 2'h1, 16'h0000);
            end
         end
      end
      end_sim();
   end
endmodule
